// *** hdl/stage_counter.v ***
// Two-stage binary counter fed by divider ticks; flags its wrap.
// Assumes tick is a one-cycle enable on the same clock.
`timescale 1ns/100ps
`default_nettype none

module stage_counter (
    input wire clk,
    input wire rst,
    input wire clear,
    input wire tick,
    output reg [1:0] count,
    output reg ovf
);

    always @(posedge clk) begin
        if (rst) begin
            count <= 2'h0;
            ovf <= 1'b0;
        end else begin
            // Clear beats a tick in the same cycle
            ovf <= ~clear & tick & (count == 2'h3); // [R3]
            if (clear) begin
                count <= 2'h0; // [R8]
            end else if (tick) begin
                count <= count + 2'h1; // [R7]
            end
        end
    end

endmodule // stage_counter

`default_nettype wire

// *** hdl/tick_divider.v ***
// Free-running divider giving one-cycle tick enables at a selectable rate.
// Assumes one clock; run low freezes the divider without clearing it.
`timescale 1ns/100ps
`default_nettype none

module tick_divider #(
    parameter DIV_W = 16,
    parameter BASE = 8
) (
    input wire clk,
    input wire rst,
    input wire run,
    input wire [1:0] sel,
    output reg tick
);

    reg [DIV_W-1:0] cnt_ff;

    // Period of tick is 2**(BASE + 2*sel) clocks
    function [DIV_W-1:0] tap_mask;
        input [1:0] s;
        integer i;
        begin
            tap_mask = {DIV_W{1'b0}};
            for (i = 0; i < DIV_W; i = i + 1) begin
                tap_mask[i] = (i < BASE + 2 * s);
            end
        end
    endfunction

    always @(posedge clk) begin
        if (rst) begin
            cnt_ff <= {DIV_W{1'b0}};
            tick <= 1'b0;
        end else begin
            if (run) begin
                cnt_ff <= cnt_ff + {{(DIV_W-1){1'b0}}, 1'b1}; // [R7]
            end
            tick <= run & ((cnt_ff & tap_mask(sel)) == tap_mask(sel));
        end
    end

endmodule // tick_divider

`default_nettype wire

// *** hdl/watchdog_defines.vh ***
// Register map, field positions, reset values and counts of the watchdog.
// Assumes a byte-addressed APB bus with 32-bit data and 12-bit addresses.
`ifndef WATCHDOG_DEFINES_VH
`define WATCHDOG_DEFINES_VH

`define WDT_ADDR_W 12
`define WDT_CTRL_OFS 12'h034
`define WDT_CMD_OFS 12'h038
`define WDT_STAT_OFS 12'h03C
`define WDT_MASK_OFS 12'h040
`define WDT_INFO_OFS 12'h044

`define WDT_EN_BIT 3
`define WDT_TSEL_LSB 1
`define WDT_TSEL_MSB 2
`define WDT_ACT_BIT 0

`define WDT_CTRL_RST 4'h9
`define WDT_CLEAR_CODE 8'h4E
`define WDT_DISABLE_CODE 8'hB1
`define WDT_STAT_OVF_BIT 0

`define WDT_DIV_BASE 8
`define WDT_DIV_W 16
`define WDT_RST_HOLD 8'h10

`endif

// *** hdl/watchdog_timer_control.v ***
// Watchdog timer with APB register access, overflow reset or interrupt.
// Assumes SYS_RST also covers the chip reset that RESET_N_OUT requests
// and LOW_POWER comes asynchronously from the power controller.
// Limitation: the block never resets itself; a bite only drives RESET_REQ and the
// reset pin, and the system must route it back into SYS_RST.
//
// Functional notes
// [R1] Watchdog is enabled and counts right after reset release.
// [R2] Control register holds enable, time, action; command register takes codes.
// [R3] Binary counter overflow activates the watchdog output.
// [R4] Action bit 1: reset request, reset pin driven low.
// [R5] Action bit 0: watchdog interrupt instead of reset.
// [R6] Counting holds in stop, idle and sleep; resumes from held count.
// [R7] Free-running divider feeds two-stage binary counter; overflow from counter.
// [R8] Clear code clears only the binary counter, not the divider.
// [R9] Clear to overflow may be only three quarters of detection time.
// [R10] Software clears faster than three quarters of detection time.
// [R11] Software sets time and action first, then clears counter.
// [R12] Software keeps clearing within the detection time.
// [R13] Enable 0 disables only with disable code; enable 1 enables.
// [R14] Action bit programmable once; reset sets it to reset request.
// [R15] With interrupt action the watchdog acts as periodic timer.
// [R16] Other command values leave counter and enable untouched.
`timescale 1ns/100ps
`default_nettype none
`include "watchdog_defines.vh"

module watchdog_timer_control #(
    parameter DIV_BASE = `WDT_DIV_BASE,
    parameter DIV_W = `WDT_DIV_W,
    parameter [7:0] DISABLE_CODE = `WDT_DISABLE_CODE
) (
    input wire CLOCK,
    input wire SYS_RST,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [`WDT_ADDR_W-1:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire LOW_POWER,
    output reg WATCHDOG_INTERRUPT,
    output reg RESET_REQ,
    output reg RESET_N_OUT
);

    localparam [2:0] REG_NONE = 3'h0;
    localparam [2:0] REG_CTRL = 3'h1;
    localparam [2:0] REG_CMD = 3'h2;
    localparam [2:0] REG_STAT = 3'h3;
    localparam [2:0] REG_MASK = 3'h4;
    localparam [2:0] REG_INFO = 3'h5;
    localparam [3:0] CTRL_RST = `WDT_CTRL_RST;

    reg en_ff;
    reg [1:0] tsel_ff;
    reg act_ff;
    reg act_lock_ff;
    reg dis_pend_ff;
    reg stat_ff;
    reg mask_ff;
    reg [7:0] rst_cnt_ff;
    reg lp_s1_ff;
    reg lp_s2_ff;
    reg lp_s3_ff;
    reg paused_ff;
    reg clear_ff;
    reg [31:0] nxt_rdata;
    reg nxt_err;

    wire tick;
    wire ovf;
    wire [1:0] count;
    wire access;
    wire wr;
    wire [2:0] sel_reg;
    wire is_clear;
    wire is_disable;
    wire set_ovf;
    wire wr_ctrl;
    wire wr_cmd;
    wire wr_stat;
    wire wr_mask;
    wire stretch;
    wire start;
    reg [7:0] nxt_rst_cnt;

    function [2:0] decode;
        input [`WDT_ADDR_W-1:0] a;
        begin
            case (a)
                `WDT_CTRL_OFS: decode = REG_CTRL;
                `WDT_CMD_OFS: decode = REG_CMD;
                `WDT_STAT_OFS: decode = REG_STAT;
                `WDT_MASK_OFS: decode = REG_MASK;
                `WDT_INFO_OFS: decode = REG_INFO;
                default: decode = REG_NONE;
            endcase
        end
    endfunction

    // Command codes must match the low byte; the upper bytes are not compared
    function cmd_is;
        input [31:0] d;
        input [7:0] code;
        begin
            cmd_is = (d[7:0] == code); // [R16]
        end
    endfunction

    // One wait state: PREADY rises in the second access cycle
    assign access = PSEL & PENABLE & PREADY;
    assign wr = access & PWRITE;
    assign sel_reg = decode(PADDR);
    assign wr_ctrl = wr & (sel_reg == REG_CTRL);
    assign wr_cmd = wr & (sel_reg == REG_CMD);
    assign wr_stat = wr & (sel_reg == REG_STAT);
    assign wr_mask = wr & (sel_reg == REG_MASK);
    assign is_clear = wr_cmd & cmd_is(PWDATA, `WDT_CLEAR_CODE); // [R16]
    assign is_disable = wr_cmd & cmd_is(PWDATA, DISABLE_CODE); // [R16]
    // Clearing the counter for the whole pulse keeps one bite one pulse
    assign stretch = (rst_cnt_ff != 8'h00);
    assign start = PSEL & PENABLE & ~PREADY;
    // Overflow while counting; the counter wraps for the next period
    assign set_ovf = ovf & en_ff & ~act_ff; // [R5] [R15]

    // Divider keeps running while the watchdog is disabled
    tick_divider #(
        .DIV_W(DIV_W),
        .BASE(DIV_BASE)
    ) u_div (
        .clk(CLOCK),
        .rst(SYS_RST),
        .run(~paused_ff), // [R6]
        .sel(tsel_ff),
        .tick(tick)
    );

    // Clear is not applied to the divider, so the first period shrinks
    stage_counter u_cnt (
        .clk(CLOCK),
        .rst(SYS_RST),
        .clear(clear_ff | ~en_ff | stretch), // [R8] [R9]
        .tick(tick & en_ff & ~paused_ff), // [R6]
        .count(count),
        .ovf(ovf)
    );

    // Three-stage sync; change counts once stages two and three agree
    always @(posedge CLOCK) begin
        if (SYS_RST) begin
            lp_s1_ff <= 1'b0;
            lp_s2_ff <= 1'b0;
            lp_s3_ff <= 1'b0;
            paused_ff <= 1'b0;
        end else begin
            lp_s1_ff <= LOW_POWER;
            lp_s2_ff <= lp_s1_ff;
            lp_s3_ff <= lp_s2_ff;
            if (lp_s2_ff == lp_s3_ff) begin
                paused_ff <= lp_s3_ff; // [R6]
            end
        end
    end

    // Clear strobe is registered, so the counter clears one cycle late
    always @(posedge CLOCK) begin
        if (SYS_RST) begin
            clear_ff <= 1'b0;
        end else begin
            clear_ff <= is_clear; // [R2] [R8]
        end
    end

    // New detection time takes hold at the divider's next tap match
    always @(posedge CLOCK) begin
        if (SYS_RST) begin
            tsel_ff <= CTRL_RST[`WDT_TSEL_MSB:`WDT_TSEL_LSB];
        end else if (wr_ctrl) begin
            tsel_ff <= PWDATA[`WDT_TSEL_MSB:`WDT_TSEL_LSB]; // [R2]
        end
    end

    // First control write locks the action, whatever value it carries
    always @(posedge CLOCK) begin
        if (SYS_RST) begin
            act_ff <= CTRL_RST[`WDT_ACT_BIT]; // [R14]
            act_lock_ff <= 1'b0;
        end else if (wr_ctrl & ~act_lock_ff) begin
            act_ff <= PWDATA[`WDT_ACT_BIT]; // [R14]
            act_lock_ff <= 1'b1; // [R14]
        end
    end

    // Two steps to disable, so one stray write cannot stop the watchdog
    always @(posedge CLOCK) begin
        if (SYS_RST) begin
            en_ff <= CTRL_RST[`WDT_EN_BIT]; // [R1]
            dis_pend_ff <= 1'b0;
        end else if (wr_ctrl) begin
            if (PWDATA[`WDT_EN_BIT]) begin
                en_ff <= 1'b1; // [R13]
                dis_pend_ff <= 1'b0;
            end else begin
                dis_pend_ff <= 1'b1; // [R13]
            end
        end else if (is_disable & dis_pend_ff) begin
            en_ff <= 1'b0; // [R13]
            dis_pend_ff <= 1'b0;
        end
    end

    // Mask gates only the pin; status still records every overflow under interrupt action (act 0)
    always @(posedge CLOCK) begin
        if (SYS_RST) begin
            mask_ff <= 1'b0;
        end else if (wr_mask) begin
            mask_ff <= PWDATA[`WDT_STAT_OVF_BIT];
        end
    end

    // Sticky status; a new overflow beats a write-one-to-clear
    always @(posedge CLOCK) begin
        if (SYS_RST) begin
            stat_ff <= 1'b0;
        end else if (set_ovf) begin
            stat_ff <= 1'b1; // [R5]
        end else if (wr_stat & PWDATA[`WDT_STAT_OVF_BIT]) begin
            stat_ff <= 1'b0;
        end
    end

    // Reset request stretch; the chip reset then reinitializes us
    always @* begin
        nxt_rst_cnt = rst_cnt_ff;
        if (ovf & en_ff & act_ff) begin
            nxt_rst_cnt = `WDT_RST_HOLD; // [R3] [R4]
        end else if (stretch) begin
            nxt_rst_cnt = rst_cnt_ff - 8'h01;
        end
    end

    always @(posedge CLOCK) begin
        if (SYS_RST) begin
            rst_cnt_ff <= 8'h00;
        end else begin
            rst_cnt_ff <= nxt_rst_cnt;
        end
    end

    // Both reset outputs come from one counter, so they never disagree
    always @(posedge CLOCK) begin
        if (SYS_RST) begin
            RESET_REQ <= 1'b0;
            RESET_N_OUT <= 1'b1;
        end else begin
            RESET_REQ <= stretch; // [R4]
            RESET_N_OUT <= ~stretch; // [R4]
        end
    end

    // Level interrupt, high while the unmasked status bit is set
    always @(posedge CLOCK) begin
        if (SYS_RST) begin
            WATCHDOG_INTERRUPT <= 1'b0;
        end else begin
            WATCHDOG_INTERRUPT <= stat_ff & mask_ff; // [R5]
        end
    end

    // Read mux and error for unmapped addresses
    always @* begin
        nxt_rdata = 32'h0000_0000;
        nxt_err = 1'b0;
        case (sel_reg)
            REG_CTRL: begin
                nxt_rdata[`WDT_EN_BIT] = en_ff;
                nxt_rdata[`WDT_TSEL_MSB:`WDT_TSEL_LSB] = tsel_ff;
                nxt_rdata[`WDT_ACT_BIT] = act_ff;
            end
            REG_CMD: nxt_rdata = 32'h0000_0000;
            REG_STAT: nxt_rdata[`WDT_STAT_OVF_BIT] = stat_ff;
            REG_MASK: nxt_rdata[`WDT_STAT_OVF_BIT] = mask_ff;
            REG_INFO: nxt_rdata[5:0] = {dis_pend_ff, act_lock_ff,
                paused_ff, en_ff, count};
            default: nxt_err = 1'b1;
        endcase
    end

    always @(posedge CLOCK) begin
        if (SYS_RST) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= start;
            // Data are captured with PREADY so they stand beside it
            if (start) begin
                PRDATA <= PWRITE ? 32'h0000_0000 : nxt_rdata;
                PSLVERR <= nxt_err;
            end else begin
                PSLVERR <= 1'b0;
            end
        end
    end

endmodule // watchdog_timer_control

`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the watchdog through its APB registers.
// Short divider (DIV_BASE 2): time 0 wraps in 16, time 1 in 64 cycles.
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic CLOCK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic LOW_POWER = 0, e;
    logic hang = 0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0000_0000, PRDATA, r;
    logic PREADY, PSLVERR, WATCHDOG_INTERRUPT, RESET_REQ, RESET_N_OUT;
    int bad_count = 0, n_checks = 0, i;
    always #2.5 CLOCK = ~CLOCK;
    // A hung access ends the run at the next edge, counted as a mismatch
    always @(posedge CLOCK) if (hang) conclude;
    watchdog_timer_control #(.DIV_BASE(2)) uut (.CLOCK(CLOCK),
        .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .LOW_POWER(LOW_POWER),
        .WATCHDOG_INTERRUPT(WATCHDOG_INTERRUPT), .RESET_REQ(RESET_REQ),
        .RESET_N_OUT(RESET_N_OUT));
    task conclude;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x) begin
            bad_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLOCK);
            k++;
        end while (PREADY !== 1'b1 && k < 20);
        if (k >= 20) begin
            bad_count++;
            hang <= 1'b1;
        end
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLOCK);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] x);
        acc(1'b0, a, 32'h0000_0000);
        chk(r, x);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask
    task cyc(input int n);
        repeat (n) @(posedge CLOCK);
    endtask
    task rst;
        SYS_RST <= 1'b1;
        cyc(2);
        SYS_RST <= 1'b0;
    endtask
    initial begin
        rst;
        // Nobody clears: the watchdog must bite on its own
        for (i = 0; i < 200 && RESET_N_OUT !== 1'b0; i++) @(posedge CLOCK);
        chk(RESET_REQ, 1);
        for (i = 0; i < 40 && RESET_N_OUT === 1'b0; i++) @(posedge CLOCK);
        chk(i, 16);
        chk(RESET_REQ, 0);
        $display("test bite done");
        rst;
        rd(12'h034, 32'h0000_0009);
        rd(12'h100, 32'h0000_0000);
        chk(e, 1);
        wr(12'h034, 32'h0000_000A);
        wr(12'h034, 32'h0000_000B);
        rd(12'h034, 32'h0000_000A);
        wr(12'h040, 32'h0000_0001);
        wr(12'h038, 32'h0000_004E);
        cyc(75);
        chk(WATCHDOG_INTERRUPT, 1);
        chk(RESET_N_OUT, 1);
        wr(12'h040, 32'h0000_0000);
        // The pin follows the mask one edge after the write lands
        cyc(1);
        chk(WATCHDOG_INTERRUPT, 0);
        wr(12'h03C, 32'h0000_0001);
        cyc(70);
        rd(12'h03C, 32'h0000_0001);
        chk(WATCHDOG_INTERRUPT, 0);
        $display("test interrupt done");
        // Clears spaced under 3/4 of the period keep status quiet
        wr(12'h038, 32'h0000_004E);
        wr(12'h03C, 32'h0000_0001);
        repeat (5) begin
            cyc(30);
            wr(12'h038, 32'h0000_004E);
        end
        rd(12'h03C, 32'h0000_0000);
        repeat (3) begin
            cyc(30);
            wr(12'h038, 32'h0000_0055);
        end
        rd(12'h03C, 32'h0000_0001);
        $display("test clear done");
        wr(12'h034, 32'h0000_0002);
        wr(12'h038, 32'h0000_00B1);
        wr(12'h03C, 32'h0000_0001);
        cyc(150);
        rd(12'h03C, 32'h0000_0000);
        wr(12'h034, 32'h0000_000A);
        cyc(75);
        rd(12'h03C, 32'h0000_0001);
        $display("test disable done");
        // Mask in, so an overflow while paused would also show on the pin
        wr(12'h038, 32'h0000_004E);
        wr(12'h03C, 32'h0000_0001);
        wr(12'h040, 32'h0000_0001);
        LOW_POWER <= 1'b1;
        cyc(150);
        rd(12'h03C, 32'h0000_0000);
        chk(WATCHDOG_INTERRUPT, 0);
        LOW_POWER <= 1'b0;
        cyc(75);
        rd(12'h03C, 32'h0000_0001);
        chk(WATCHDOG_INTERRUPT, 1);
        $display("test pause done");
        conclude;
    end
endmodule // tb
`default_nettype wire

// *** verif/wdt_chk.sv ***
// Port checks for the watchdog: APB answer, reset pin, interrupt, pause.
// Bound to watchdog_timer_control; one clock, SYS_RST sync active high.
`timescale 1ns/100ps
`default_nettype none
module wdt_chk (
    input wire CLOCK,
    input wire SYS_RST,
    input wire PSEL,
    input wire PENABLE,
    input wire [31:0] PRDATA,
    input wire PREADY,
    input wire PSLVERR,
    input wire LOW_POWER,
    input wire WATCHDOG_INTERRUPT,
    input wire RESET_REQ,
    input wire RESET_N_OUT
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (SYS_RST);
    pin_follow_a: assert property (RESET_N_OUT == !RESET_REQ)
        else $error("reset pin differs from request");
    req_pulse_a: assert property ($rose(RESET_REQ) |->
        RESET_REQ [*8] ##1 RESET_REQ [*8] ##1 !RESET_REQ)
        else $error("reset request not 16 cycles");
    irq_excl_a: assert property ($rose(WATCHDOG_INTERRUPT) |->
        RESET_N_OUT)
        else $error("interrupt together with reset");
    ready_one_a: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    ready_lat_a: assert property ($rose(PSEL && PENABLE) |->
        ##[0:2] PREADY)
        else $error("no ready after access");
    err_data_a: assert property (PSLVERR |->
        PREADY && PRDATA == 32'h0000_0000)
        else $error("error answer malformed");
    rst_state_a: assert property ($fell(SYS_RST) |->
        RESET_N_OUT && !WATCHDOG_INTERRUPT && !PREADY)
        else $error("outputs active after reset");
    pause_hold_a: assert property (LOW_POWER [*8] |->
        !$rose(RESET_REQ) && !$rose(WATCHDOG_INTERRUPT))
        else $error("overflow while paused");
    cover property ($rose(RESET_REQ));
    cover property ($rose(WATCHDOG_INTERRUPT));
    cover property (PSLVERR);
endmodule // wdt_chk
bind watchdog_timer_control wdt_chk chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .LOW_POWER(LOW_POWER),
    .WATCHDOG_INTERRUPT(WATCHDOG_INTERRUPT), .RESET_REQ(RESET_REQ),
    .RESET_N_OUT(RESET_N_OUT));
`default_nettype wire
